// ### rtl/apd_defs.svh
// Constants for the automatic power-down controller
// Function
// - Enabled unit runs four-bit idle counter on general clock once strobe stops.
// - Strobe idle fifteen general clock periods asserts power-down.
// - Enabling the unit alone permits power-down entry.
// - Strobe pulsing again returns the device to normal operation.
// - Chip select returning low or reset returning high also wakes.
// - Power-down blocks MCU bus from memories and both logic arrays.
// - Power-down deselects all memories internally, keeping them in standby.
// - Array clock blocking bit never blocks the clock to the idle counter.
// - Logic arrays and ports stay operational during power-down.
// - Power-down holds I/O levels, address outputs undefined, data/peripheral pins tri-state.
// - Array behaviour depends only on the full-speed bit, not power-down.
// - Chip select high disables memories and I/O space, not arrays.
// - Power registers writable anytime; set blocking bits stop signals reaching arrays.
// - Full speed on by default; when off, arrays idle if inputs static.
// - Toggling unblocked array input keeps arrays active, memories unaffected.
// - Memory idles while inputs stable, wakes one cycle on a transition.
// - Dedicated clock pin clocks macrocells and the idle counter.
// - Power options beyond memory standby and chip select come from registers.
// - Register 0 bit 1 enables the power-down unit.
// - Counter idle when disabled or strobe pulsing; counts at idle polarity.
// - Power registers clear at power-up only, not on reset pin pulses.
// - Reg0 bits 3,4,5 and reg2 bits 2 to 6 select savings.
`ifndef POWER_DEFS_SVH
`define POWER_DEFS_SVH
`define IDLE_LIMIT 4'hf
`define PIN_SYNC_RESET 8'h08
`define PCR0_SLEEP_EN_BIT 1
`define PCR0_TURBO_OFF_BIT 3
`define PCR0_ARRAY_CLK_OFF_BIT 4
`define PCR0_MCELL_CLK_OFF_BIT 5
`define PCR2_CTRL0_OFF_BIT 2
`define PCR2_CTRL1_OFF_BIT 3
`define PCR2_CTRL2_OFF_BIT 4
`define PCR2_STROBE_OFF_BIT 5
`define PCR2_BYTE_EN_OFF_BIT 6
`define PCR0_WRITE_MASK 8'h3a
`define PCR2_WRITE_MASK 8'h7c
`define PCR_RESET_VALUE 8'h00
`endif

// ### rtl/apd_pkg.sv
// Types for the automatic power-down controller
package sleep_pkg;
  typedef enum logic [0:0] {
    PD_RUN = 1'b0,
    PD_SLEEP = 1'b1
  } pd_state_t;
endpackage

// ### rtl/auto_powerdown_control.sv
// Automatic power-down unit, power registers and signal blocking
`timescale 1ns/1ps
`default_nettype none
`include "apd_defs.svh"
module auto_powerdown_control
  import sleep_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int COUNT_W = 4
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic ADDRESS_STROBE_IN,
  input wire logic GENERAL_CLOCK_IN,
  input wire logic CHIP_SELECT_N,
  input wire logic RESET_IN_N,
  input wire logic CONTROL_INPUT0,
  input wire logic CONTROL_INPUT1,
  input wire logic CONTROL_INPUT2,
  input wire logic BYTE_ENABLE_IN,
  input wire logic [DATA_W-1:0] ADDR_DATA_IN,
  input wire logic STROBE_IDLE_LEVEL,
  input wire logic PCR0_WR,
  input wire logic PCR2_WR,
  input wire logic [7:0] PCR_WDATA,
  input wire logic DATA_PORT_DRIVE_REQ,
  input wire logic PERIPH_DRIVE_REQ,
  output logic [7:0] POWER_CTRL_REG0,
  output logic [7:0] POWER_CTRL_REG2,
  output logic POWERDOWN_ACTIVE,
  output logic [COUNT_W-1:0] IDLE_COUNT,
  output logic BUS_TO_ARRAYS_EN,
  output logic [DATA_W-1:0] ADDR_DATA_TO_ARRAYS,
  output logic MEM_SELECT,
  output logic IO_SPACE_SELECT,
  output logic MEM_STANDBY,
  output logic ARRAY_CLK_OUT,
  output logic MCELL_CLK_OUT,
  output logic CTRL0_TO_ARRAY,
  output logic CTRL1_TO_ARRAY,
  output logic CTRL2_TO_ARRAY,
  output logic STROBE_TO_ARRAY,
  output logic BYTE_EN_TO_ARRAY,
  output logic ARRAY_FULL_SPEED,
  output logic ARRAY_STANDBY,
  output logic DATA_PORT_OE,
  output logic PERIPH_OE,
  output logic ADDR_OUT_VALID
);

  localparam int SYNC_W = DATA_W + 8;

  // Elaboration stops on widths the counter or bus cannot serve
  if (COUNT_W < 4 || int'(`IDLE_LIMIT) >= (1 << COUNT_W)) begin : g_count_w_check
    $error("COUNT_W too narrow for the idle limit");
  end
  if (DATA_W < 1) begin : g_data_w_check
    $error("DATA_W must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops before any logic
  logic [SYNC_W-1:0] pin_meta_reg;
  logic [SYNC_W-1:0] pin_sync_reg;
  logic [SYNC_W-1:0] pin_prev_reg;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      // Reset pin rests high, so its rise detector must not see a false edge
      pin_meta_reg <= SYNC_W'(`PIN_SYNC_RESET);
      pin_sync_reg <= SYNC_W'(`PIN_SYNC_RESET);
      pin_prev_reg <= SYNC_W'(`PIN_SYNC_RESET);
    end else begin
      pin_meta_reg <= {ADDR_DATA_IN, BYTE_ENABLE_IN, CONTROL_INPUT2, CONTROL_INPUT1,
                       CONTROL_INPUT0, RESET_IN_N, CHIP_SELECT_N, GENERAL_CLOCK_IN,
                       ADDRESS_STROBE_IN};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic strobe_s;
  logic gclk_s;
  logic cs_n_s;
  logic rst_n_s;
  logic [DATA_W-1:0] ad_s;
  logic strobe_edge;
  logic gclk_rise;
  logic cs_fall;
  logic rst_rise;
  logic wake;
  logic ad_change;

  assign strobe_s = pin_sync_reg[0];
  assign gclk_s = pin_sync_reg[1];
  assign cs_n_s = pin_sync_reg[2];
  assign rst_n_s = pin_sync_reg[3];
  assign ad_s = pin_sync_reg[SYNC_W-1:8];
  assign strobe_edge = strobe_s ^ pin_prev_reg[0];
  assign gclk_rise = gclk_s & ~pin_prev_reg[1];
  assign cs_fall = ~cs_n_s & pin_prev_reg[2];
  assign rst_rise = rst_n_s & ~pin_prev_reg[3];
  assign ad_change = |(ad_s ^ pin_prev_reg[SYNC_W-1:8]);
  assign wake = strobe_edge | cs_fall | rst_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Power registers, cleared by power-up reset only
  logic [7:0] pcr0_reg;
  logic [7:0] pcr2_reg;

  // The reset pin is not part of this reset, so its pulses keep settings
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pcr0_reg <= `PCR_RESET_VALUE;
      pcr2_reg <= `PCR_RESET_VALUE;
    end else begin
      if (PCR0_WR) begin
        pcr0_reg <= PCR_WDATA & `PCR0_WRITE_MASK;
      end
      if (PCR2_WR) begin
        pcr2_reg <= PCR_WDATA & `PCR2_WRITE_MASK;
      end
    end
  end

  logic sleep_en;
  logic turbo_off;
  assign sleep_en = pcr0_reg[`PCR0_SLEEP_EN_BIT];
  assign turbo_off = pcr0_reg[`PCR0_TURBO_OFF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Idle counter and power-down state
  logic [COUNT_W-1:0] cnt_reg;
  pd_state_t pd_state_reg;
  logic strobe_idle;
  logic count_step;
  logic enter_pd;

  assign strobe_idle = ~strobe_edge & (strobe_s == STROBE_IDLE_LEVEL);
  // Counter sees the raw general clock whatever the blocking bits say
  assign count_step = sleep_en & gclk_rise & strobe_idle & ~wake;
  assign enter_pd = count_step & (cnt_reg == COUNT_W'(`IDLE_LIMIT - 1));

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cnt_reg <= '0;
    end else if (!sleep_en || strobe_edge || wake) begin
      cnt_reg <= '0;
    end else if (count_step && cnt_reg != COUNT_W'(`IDLE_LIMIT)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pd_state_reg <= PD_RUN;
    end else begin
      case (pd_state_reg)
        PD_RUN: begin
          if (enter_pd) begin
            pd_state_reg <= PD_SLEEP;
          end
        end
        PD_SLEEP: begin
          if (wake || !sleep_en) begin
            pd_state_reg <= PD_RUN;
          end
        end
        default: begin
          pd_state_reg <= PD_RUN;
        end
      endcase
    end
  end

  logic pd;
  assign pd = (pd_state_reg == PD_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Bus blocking and memory select
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      POWERDOWN_ACTIVE <= 1'b0;
      IDLE_COUNT <= '0;
      BUS_TO_ARRAYS_EN <= 1'b1;
      ADDR_DATA_TO_ARRAYS <= '0;
      POWER_CTRL_REG0 <= `PCR_RESET_VALUE;
      POWER_CTRL_REG2 <= `PCR_RESET_VALUE;
    end else begin
      POWERDOWN_ACTIVE <= pd;
      IDLE_COUNT <= cnt_reg;
      POWER_CTRL_REG0 <= pcr0_reg;
      POWER_CTRL_REG2 <= pcr2_reg;
      BUS_TO_ARRAYS_EN <= ~pd;
      if (!pd) begin
        ADDR_DATA_TO_ARRAYS <= ad_s;
      end
    end
  end

  // Chip select only touches memories and register space, never arrays
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      MEM_SELECT <= 1'b0;
      IO_SPACE_SELECT <= 1'b0;
      MEM_STANDBY <= 1'b1;
    end else begin
      MEM_SELECT <= ~pd & ~cs_n_s;
      IO_SPACE_SELECT <= ~pd & ~cs_n_s;
      MEM_STANDBY <= pd | cs_n_s | ~ad_change;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array input blocking, independent of power-down
  logic [6:0] arr_in;
  logic [6:0] arr_in_prev_reg;
  logic arr_toggle;

  assign arr_in[0] = gclk_s & ~pcr0_reg[`PCR0_ARRAY_CLK_OFF_BIT];
  assign arr_in[1] = gclk_s & ~pcr0_reg[`PCR0_MCELL_CLK_OFF_BIT];
  assign arr_in[2] = pin_sync_reg[4] & ~pcr2_reg[`PCR2_CTRL0_OFF_BIT];
  assign arr_in[3] = pin_sync_reg[5] & ~pcr2_reg[`PCR2_CTRL1_OFF_BIT];
  assign arr_in[4] = pin_sync_reg[6] & ~pcr2_reg[`PCR2_CTRL2_OFF_BIT];
  assign arr_in[5] = strobe_s & ~pcr2_reg[`PCR2_STROBE_OFF_BIT];
  assign arr_in[6] = pin_sync_reg[7] & ~pcr2_reg[`PCR2_BYTE_EN_OFF_BIT];
  assign arr_toggle = |(arr_in ^ arr_in_prev_reg);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      arr_in_prev_reg <= '0;
      {BYTE_EN_TO_ARRAY, STROBE_TO_ARRAY, CTRL2_TO_ARRAY, CTRL1_TO_ARRAY,
       CTRL0_TO_ARRAY, MCELL_CLK_OUT, ARRAY_CLK_OUT} <= '0;
    end else begin
      arr_in_prev_reg <= arr_in;
      {BYTE_EN_TO_ARRAY, STROBE_TO_ARRAY, CTRL2_TO_ARRAY, CTRL1_TO_ARRAY,
       CTRL0_TO_ARRAY, MCELL_CLK_OUT, ARRAY_CLK_OUT} <= arr_in;
    end
  end

  // Standby ignores power-down: only the full-speed bit and toggling count
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ARRAY_FULL_SPEED <= 1'b1;
      ARRAY_STANDBY <= 1'b0;
    end else begin
      ARRAY_FULL_SPEED <= ~turbo_off;
      ARRAY_STANDBY <= turbo_off & ~arr_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port pin states; I/O and array outputs are left alone
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DATA_PORT_OE <= 1'b0;
      PERIPH_OE <= 1'b0;
      ADDR_OUT_VALID <= 1'b0;
    end else begin
      DATA_PORT_OE <= DATA_PORT_DRIVE_REQ & ~pd;
      PERIPH_OE <= PERIPH_DRIVE_REQ & ~pd;
      ADDR_OUT_VALID <= ~pd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence idle_walk_s;
    pd_state_reg == PD_RUN && enter_pd;
  endsequence

  sequence sleep_wake_s;
    pd_state_reg == PD_SLEEP && wake;
  endsequence

  pd_entry_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      idle_walk_s |=> pd ##1 POWERDOWN_ACTIVE)
    else $error("Power-down not entered after idle limit");

  pd_hold_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      pd && !wake && sleep_en |=> cnt_reg == COUNT_W'(`IDLE_LIMIT))
    else $error("Counter left terminal count in power-down");

  count_off_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      !sleep_en |=> cnt_reg == '0 && !pd)
    else $error("Counter active while unit disabled");

  strobe_clear_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      strobe_edge |=> cnt_reg == '0)
    else $error("Strobe transition did not clear counter");

  wake_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      sleep_wake_s |=> !pd ##1 !POWERDOWN_ACTIVE && BUS_TO_ARRAYS_EN)
    else $error("No wake after activity");

  clk_pass_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      count_step && pcr0_reg[`PCR0_ARRAY_CLK_OFF_BIT] && cnt_reg < COUNT_W'(`IDLE_LIMIT)
      |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("Blocked array clock stopped the counter");

  bus_block_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      POWERDOWN_ACTIVE |-> !BUS_TO_ARRAYS_EN && !MEM_SELECT && MEM_STANDBY)
    else $error("Bus reaches memories in power-down");

  cs_block_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      cs_n_s |=> !MEM_SELECT && !IO_SPACE_SELECT)
    else $error("Memories selected with chip select high");

  ctrl_block_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      pcr2_reg[`PCR2_CTRL0_OFF_BIT] |=> !CTRL0_TO_ARRAY)
    else $error("Blocked control reached the arrays");

  turbo_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      !turbo_off |=> ARRAY_FULL_SPEED && !ARRAY_STANDBY)
    else $error("Array standby with full speed on");

  tristate_a:
    assert property (@(posedge SYS_CLK) disable iff (RST)
      pd |=> !DATA_PORT_OE && !PERIPH_OE)
    else $error("Data port driven in power-down");

endmodule
`default_nettype wire

// ### test/mcu_bus_model.sv
// MCU-side model: address strobe, general clock and address/data lines
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_model #(
  parameter int GCLK_HALF = 5
) (
  input wire logic clk,
  input wire logic strobe_run,
  input wire logic gclk_run,
  input wire logic bus_walk,
  input wire logic idle_level,
  output logic strobe,
  output logic gclk,
  output logic [7:0] addr_data
);
  int gdiv;
  initial {strobe, gclk, addr_data, gdiv} = '0;
  ////////////////////////////////////////
  // Controls sampled on the rising edge so they never race the bench
  always @(posedge clk) begin
    strobe <= strobe_run ? ~strobe : idle_level;
    if (bus_walk) begin
      addr_data <= addr_data ^ (8'($urandom) | 8'h01);
    end
  end
  // Runs while the MCU sleeps, well under 15x the strobe rate
  always @(posedge clk) begin
    gdiv <= (!gclk_run || gdiv == GCLK_HALF - 1) ? 0 : gdiv + 1;
    if (!gclk_run) begin
      gclk <= 1'b0;
    end else if (gdiv == GCLK_HALF - 1) begin
      gclk <= ~gclk;
    end
  end
endmodule
`default_nettype wire

// ### test/auto_powerdown_control_test.sv
// Self-checking bench for the automatic power-down controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module auto_powerdown_control_test;
  logic clk, rst, cs_n, rst_in_n, c0, c1, c2, be, idle_lvl, wr0, wr2, dreq, preq;
  logic strobe_run, gclk_run, bus_walk, strobe, gclk, seen_low, park;
  logic pda, bus_en, msel, iosel, mstby, aclk, mclk, k0, k1, k2, kstb, kbe, fs, astby;
  logic doe, poe, aov;
  logic [3:0] cnt;
  logic [7:0] addr, wdata, reg0, reg2, adta, held, r0, r2;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  mcu_bus_model #(.GCLK_HALF(5)) mcu (.clk(clk), .strobe_run(strobe_run),
    .gclk_run(gclk_run), .bus_walk(bus_walk), .idle_level(park), .strobe(strobe),
    .gclk(gclk), .addr_data(addr));
  auto_powerdown_control uut (.SYS_CLK(clk), .RST(rst), .ADDRESS_STROBE_IN(strobe),
    .GENERAL_CLOCK_IN(gclk), .CHIP_SELECT_N(cs_n), .RESET_IN_N(rst_in_n),
    .CONTROL_INPUT0(c0), .CONTROL_INPUT1(c1), .CONTROL_INPUT2(c2), .BYTE_ENABLE_IN(be),
    .ADDR_DATA_IN(addr), .STROBE_IDLE_LEVEL(idle_lvl), .PCR0_WR(wr0), .PCR2_WR(wr2),
    .PCR_WDATA(wdata), .DATA_PORT_DRIVE_REQ(dreq), .PERIPH_DRIVE_REQ(preq),
    .POWER_CTRL_REG0(reg0), .POWER_CTRL_REG2(reg2), .POWERDOWN_ACTIVE(pda),
    .IDLE_COUNT(cnt), .BUS_TO_ARRAYS_EN(bus_en), .ADDR_DATA_TO_ARRAYS(adta),
    .MEM_SELECT(msel), .IO_SPACE_SELECT(iosel), .MEM_STANDBY(mstby), .ARRAY_CLK_OUT(aclk),
    .MCELL_CLK_OUT(mclk), .CTRL0_TO_ARRAY(k0), .CTRL1_TO_ARRAY(k1), .CTRL2_TO_ARRAY(k2),
    .STROBE_TO_ARRAY(kstb), .BYTE_EN_TO_ARRAY(kbe), .ARRAY_FULL_SPEED(fs),
    .ARRAY_STANDBY(astby), .DATA_PORT_OE(doe), .PERIPH_OE(poe), .ADDR_OUT_VALID(aov));
  ////////////////////////////////////////
  function automatic logic [7:0] masked(input logic sel2, input logic [7:0] d);
    return d & (sel2 ? 8'h7c : 8'h3a);
  endfunction
  function automatic logic [3:0] gated(input logic [3:0] v, input logic [7:0] b);
    return v & ~{b[2], b[3], b[4], b[6]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic sel2, input logic [7:0] d);
    wdata = d;
    wr0 = !sel2;
    wr2 = sel2;
    tick(1);
    wr0 = 1'b0;
    wr2 = 1'b0;
    // One idle edge so a following write never re-raises a strobe in this step
    tick(1);
  endtask
  // Gap of 7 cycles lets the sync pipeline land before the next clock rise
  task automatic rises(input int n);
    repeat (n) @(posedge gclk);
    tick(7);
  endtask
  task automatic enter(input int n);
    strobe_run = 1'b0;
    gclk_run = 1'b0;
    tick(6);
    gclk_run = 1'b1;
    rises(n);
  endtask
  task automatic watch(input int n);
    seen_low = 1'b0;
    repeat (n) begin
      tick(1);
      seen_low = seen_low | (mstby === 1'b0);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    {cs_n, c0, c1, c2, be, wr0, wr2, dreq, preq, strobe_run, gclk_run, bus_walk} = '0;
    {rst, rst_in_n, wdata} = {2'b11, 8'h00};
    void'($urandom(99888));
    idle_lvl = 1'($urandom);
    park = idle_lvl;
    tick(5);
    rst = 1'b0;
    tick(3);
    `CHK({reg0, reg2}, 16'h0000)
    `CHK({fs, pda}, 2'b10)
    gclk_run = 1'b1;
    rises(20);
    `CHK({pda, cnt}, 5'h00)
    wr(1'b0, 8'h02);
    strobe_run = 1'b1;
    rises(20);
    `CHK({pda, cnt}, 5'h00)
    {dreq, preq} = 2'b11;
    // Random blocking bits and pin levels while the MCU is busy
    for (int i = 0; i < 16; i++) begin
      r0 = 8'($urandom);
      r2 = 8'($urandom);
      {c0, c1, c2, be, cs_n} = 5'($urandom);
      wr(1'b0, r0);
      wr(1'b1, r2);
      tick(6);
      `CHK(reg0, masked(1'b0, r0))
      `CHK(reg2, masked(1'b1, r2))
      `CHK(fs, ~r0[3])
      `CHK({k0, k1, k2, kbe}, gated({c0, c1, c2, be}, r2))
      `CHK({msel, iosel, bus_en, doe, poe, aov}, {~cs_n, ~cs_n, 4'hf})
      if (r2[5]) `CHK(kstb, 1'b0)
      if (r0[4]) `CHK(aclk, 1'b0)
      if (r0[5]) `CHK(mclk, 1'b0)
      if (!r0[3] || !r2[5]) `CHK(astby, 1'b0)
    end
    {cs_n, c0, c1, c2, be} = '0;
    tick(6);
    `CHK({mstby, adta}, {1'b1, addr})
    bus_walk = 1'b1;
    tick(1);
    bus_walk = 1'b0;
    watch(6);
    `CHK({seen_low, mstby}, 2'b11)
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h3a);
    enter(14);
    `CHK({pda, cnt}, 5'h0e)
    rises(1);
    `CHK({pda, cnt}, 5'h1f)
    `CHK({bus_en, msel, iosel, doe, poe, aov, aclk}, 7'h00)
    `CHK({astby, fs}, 2'b10)
    held = adta;
    bus_walk = 1'b1;
    watch(8);
    bus_walk = 1'b0;
    `CHK({seen_low, adta}, {1'b0, held})
    rises(2);
    `CHK({pda, cnt}, 5'h1f)
    repeat (6) begin
      c0 = ~c0;
      tick(1);
    end
    `CHK({astby, mstby}, 2'b01)
    c0 = 1'b1;
    tick(6);
    `CHK({k0, pda}, 2'b11)
    // Each wake cause in turn; registers must survive the reset pin
    for (int k = 0; k < 3; k++) begin
      enter(15);
      `CHK(pda, 1'b1)
      gclk_run = 1'b0;
      case (k)
        0: strobe_run = 1'b1;
        1: begin
          cs_n = 1'b1;
          tick(3);
          cs_n = 1'b0;
        end
        default: begin
          rst_in_n = 1'b0;
          tick(3);
          rst_in_n = 1'b1;
        end
      endcase
      tick(7);
      `CHK({pda, cnt, bus_en}, 6'h01)
      `CHK(reg0, 8'h3a)
    end
    // Strobe parked at the busy level must not count
    park = ~idle_lvl;
    gclk_run = 1'b1;
    rises(3);
    `CHK({pda, cnt}, 5'h00)
    // Power-up reset in mid-run clears the power registers
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    `CHK({reg0, reg2, pda}, 17'h00000)
    conclude();
  end
endmodule
`default_nettype wire
